// file: core/fcsc_host.sv
// Host-side controller that drives a parallel sector-erase flash through its pins.
`timescale 1ns/1ps
`include "fcsc_regs.svh"
module fcsc_host import fcsc_pkg::*; #(
   parameter int AW = 21
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire fcsc_req_type req,
   output logic req_ready,
   output logic resp_valid,
   output logic [7:0] resp_data,
   output fcsc_stat_type resp_stat,
   output logic [AW-1:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic reset_powerdown_n,
   input wire logic ready_busy_out,
   input wire logic programming_supply_ok_level,
   input wire logic powerdown_req
);
   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   logic [7:0] dq_s1_r, dq_s2_r;
   logic rb_s1_r, rb_s2_r;
   logic vpp_s1_r, vpp_s2_r;
   // Pins are asynchronous to clk, so each passes two flops before use.
   always_ff @(posedge clk) begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_out;
      rb_s2_r <= rb_s1_r;
      vpp_s1_r <= programming_supply_ok_level; // RULE27
      vpp_s2_r <= vpp_s1_r;
   end

   // ------------------------------------------------------------------------
   // Bus sequencer
   // ------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR1 = 3'b001,
      ST_GAP = 3'b010,
      ST_WR2 = 3'b011,
      ST_RD = 3'b100,
      ST_DONE = 3'b101
   } fcsc_state_type;
   fcsc_state_type state_r;
   logic [3:0] cnt_r;
   fcsc_req_type cur_r;
   logic [7:0] cmd1_r;
   logic two_r;
   logic err_lock_r;
   logic [7:0] cmd1_nxt;
   logic two_nxt, rd_nxt;

   // First command byte and whether a second write or a read follows.
   always_comb begin
      cmd1_nxt = `FCSC_CMD_READ_STATUS;
      two_nxt = 1'b0;
      rd_nxt = 1'b0;
      unique case (req.op)
         FCSC_OP_READ_ARRAY: cmd1_nxt = `FCSC_CMD_READ_ARRAY; // RULE23 RULE19
         FCSC_OP_READ_STATUS: begin
            cmd1_nxt = `FCSC_CMD_READ_STATUS; // RULE24
            rd_nxt = 1'b1;
         end
         FCSC_OP_PROGRAM: begin
            cmd1_nxt = `FCSC_CMD_PROG_SETUP; // RULE25
            two_nxt = 1'b1;
         end
         FCSC_OP_ERASE: begin
            cmd1_nxt = `FCSC_CMD_ERASE_SETUP; // RULE26
            two_nxt = 1'b1;
         end
         FCSC_OP_CLEAR: cmd1_nxt = `FCSC_CMD_CLEAR_STATUS; // RULE9 RULE10 RULE28
         FCSC_OP_SUSPEND: cmd1_nxt = `FCSC_CMD_SUSPEND; // RULE11
         FCSC_OP_RESUME: cmd1_nxt = `FCSC_CMD_CONFIRM; // RULE16
         FCSC_OP_READ: rd_nxt = 1'b1;
      endcase
   end

   // Program and erase are held back after an error until cleared; the device
   // would ignore them anyway and the user would poll a stale status.
   logic accept;
   assign accept = req_valid && req_ready &&
      !(err_lock_r && (req.op == FCSC_OP_PROGRAM || req.op == FCSC_OP_ERASE)); // RULE22 RULE18

   // Walks a plain read through a read phase alone, program and erase through two writes, read-status through write and read, others through one write.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r <= `FCSC_CNT_ZERO;
         cur_r <= '0;
         cmd1_r <= 8'h00;
         two_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: if (accept) begin
               cur_r <= req;
               cmd1_r <= cmd1_nxt;
               two_r <= two_nxt;
               cnt_r <= 4'(`FCSC_WR_CYC);
               state_r <= (req.op == FCSC_OP_READ) ? ST_RD : ST_WR1;
               if (req.op == FCSC_OP_READ) cnt_r <= 4'(`FCSC_RD_CYC);
            end
            ST_WR1: if (cnt_r == `FCSC_CNT_ZERO) begin
               cnt_r <= 4'(`FCSC_WR_CYC);
               state_r <= two_r ? ST_GAP : (rd_flag(cur_r.op) ? ST_GAP : ST_DONE);
            end else cnt_r <= cnt_r - 4'h1;
            ST_GAP: begin
               cnt_r <= two_r ? 4'(`FCSC_WR_CYC) : 4'(`FCSC_RD_CYC);
               state_r <= two_r ? ST_WR2 : ST_RD;
            end
            ST_WR2: if (cnt_r == `FCSC_CNT_ZERO) state_r <= ST_DONE;
               else cnt_r <= cnt_r - 4'h1;
            ST_RD: if (cnt_r == `FCSC_CNT_ZERO) state_r <= ST_DONE;
               else cnt_r <= cnt_r - 4'h1;
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   function automatic logic rd_flag(input fcsc_op_type op);
      rd_flag = (op == FCSC_OP_READ_STATUS);
   endfunction : rd_flag

   // ------------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------------
   // Write data is the command byte in the first write and the user byte or
   // confirm code in the second.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_addr <= '0;
         flash_dq_out <= 8'h00;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
      end else begin
         flash_ce_n <= !(state_r == ST_WR1 || state_r == ST_WR2 || state_r == ST_RD);
         flash_we_n <= !(state_r == ST_WR1 || state_r == ST_WR2);
         flash_oe_n <= !(state_r == ST_RD);
         flash_dq_oe <= (state_r == ST_WR1 || state_r == ST_WR2);
         flash_addr <= cur_r.addr[AW-1:0];
         if (state_r == ST_WR2)
            flash_dq_out <= (cur_r.op == FCSC_OP_ERASE) ? `FCSC_CMD_CONFIRM : cur_r.data;
         else
            flash_dq_out <= cmd1_r;
      end
   end

   // Power-down pin follows the user's request; dropping it aborts any
   // operation and resets the device command interface to array read.
   always_ff @(posedge clk) begin
      if (!rst_n) reset_powerdown_n <= 1'b0;
      else reset_powerdown_n <= !powerdown_req; // RULE6 RULE15 RULE20
   end

   // ------------------------------------------------------------------------
   // Answer and error tracking
   // ------------------------------------------------------------------------
   logic [7:0] sampled;
   assign sampled = dq_s2_r;
   // Data is taken from the synchronised bus at the end of the read phase.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_data <= 8'h00;
         resp_stat <= '0;
         req_ready <= 1'b0;
      end else begin
         resp_valid <= (state_r == ST_DONE);
         req_ready <= (state_r == ST_IDLE) && !accept && !powerdown_req;
         if (state_r == ST_RD && cnt_r == `FCSC_CNT_ZERO) begin
            resp_data <= sampled;
            resp_stat.ready <= sampled[`FCSC_SR_READY] && rb_s2_r; // RULE3 RULE7 RULE29
            resp_stat.suspended <= sampled[`FCSC_SR_SUSP]; // RULE12 RULE17
            resp_stat.erase_err <= sampled[`FCSC_SR_ERASE_ERR]; // RULE21
            resp_stat.prog_err <= sampled[`FCSC_SR_PROG_ERR]; // RULE4 RULE8
            resp_stat.supply_err <= sampled[`FCSC_SR_SUPPLY_ERR] || !vpp_s2_r; // RULE5
         end
      end
   end

   // Lock is set on an error bit in a read-status answer; a clear-status write releases it.
   // A new error seen in the same cycle as a clear keeps the lock.
   logic err_seen;
   assign err_seen = (state_r == ST_RD) && (cnt_r == `FCSC_CNT_ZERO) && rd_flag(cur_r.op) &&
      (sampled[`FCSC_SR_ERASE_ERR] || sampled[`FCSC_SR_PROG_ERR] ||
       sampled[`FCSC_SR_SUPPLY_ERR]);
   always_ff @(posedge clk) begin
      if (!rst_n) err_lock_r <= 1'b0;
      else if (err_seen) err_lock_r <= 1'b1; // RULE6 RULE18
      else if (state_r == ST_DONE && cur_r.op == FCSC_OP_CLEAR) err_lock_r <= 1'b0; // RULE10
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   a_write_strobes: assert property (@(posedge clk) disable iff (!rst_n)
      !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("Write strobe without chip enable or data drive."); // RULE25
   a_no_contention: assert property (@(posedge clk) disable iff (!rst_n)
      !flash_oe_n |-> !flash_dq_oe)
      else $error("Data driven during a read.");
   a_erase_confirm: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == ST_WR2 && cur_r.op == FCSC_OP_ERASE) |=> flash_dq_out == `FCSC_CMD_CONFIRM)
      else $error("Erase second write is not the confirm code."); // RULE26
   a_clear_code: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == ST_WR1 && cur_r.op == FCSC_OP_CLEAR) |=> flash_dq_out == `FCSC_CMD_CLEAR_STATUS)
      else $error("Clear-status wrote wrong byte."); // RULE9
   a_lock_refuse: assert property (@(posedge clk) disable iff (!rst_n)
      (err_lock_r && req_valid && req_ready && req.op == FCSC_OP_PROGRAM) |=> state_r == ST_IDLE)
      else $error("Program accepted while error lock set."); // RULE22
   a_lock_set: assert property (@(posedge clk) disable iff (!rst_n)
      err_seen |=> err_lock_r)
      else $error("Error not latched."); // RULE18
   a_resp_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      resp_valid |=> !resp_valid)
      else $error("Answer held longer than one cycle.");
   a_pd_follow: assert property (@(posedge clk) disable iff (!rst_n)
      powerdown_req |=> !reset_powerdown_n)
      else $error("Power-down pin did not follow request."); // RULE20
endmodule : fcsc_host

// file: core/fcsc_regs.svh
// Command codes, status bit positions and bus timing for the flash host controller.
// Contract
// RULE1 - Program clears bits; only erase restores ones
// RULE2 - While programming only read-status is accepted
// RULE3 - Status bit 7 low busy, high done
// RULE4 - Status bit 4 flags program failure
// RULE5 - Status bit 3 flags low programming supply
// RULE6 - Abort needs clear, erase and reprogram
// RULE7 - Ready/busy shows busy during program
// RULE8 - Host checks bits 3 and 4 after programming
// RULE9 - Clear-status resets bits 3, 4, 5
// RULE10 - Clear-status returns to array read
// RULE11 - Suspend command suspends running erase
// RULE12 - Bit 6 shows suspended or already finished
// RULE13 - Suspended: only read, status, resume accepted
// RULE14 - After suspend reads give status first
// RULE15 - Abort in suspend sets bits 3, 5
// RULE16 - Resume command restarts suspended erase
// RULE17 - Resume clears bit 6, reads give status
// RULE18 - After error, clear status before array read
// RULE19 - After success, read or clear before reading
// RULE20 - Command interface defaults to array read
// RULE21 - Bad erase sequence sets bits 4 and 5
// RULE22 - After command error, refuse program and erase
// RULE23 - Read command selects array read mode
// RULE24 - Read-status command accepted at any time
// RULE25 - Program is setup write then address/data
// RULE26 - Erase is setup then confirm with address
// RULE27 - Supply-ok is a synchronous sampled flag
// RULE28 - Clear-status decoded from one command byte
// RULE29 - Ready when idle, suspended or powered down
`ifndef FCSC_REGS_SVH
`define FCSC_REGS_SVH
// ----------------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------------
`define FCSC_CMD_READ_ARRAY 8'hff
`define FCSC_CMD_READ_STATUS 8'h70
`define FCSC_CMD_PROG_SETUP 8'h40
`define FCSC_CMD_ERASE_SETUP 8'h20
`define FCSC_CMD_CONFIRM 8'hd0
`define FCSC_CMD_CLEAR_STATUS 8'h50
`define FCSC_CMD_SUSPEND 8'hb0
// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define FCSC_SR_READY 7
`define FCSC_SR_SUSP 6
`define FCSC_SR_ERASE_ERR 5
`define FCSC_SR_PROG_ERR 4
`define FCSC_SR_SUPPLY_ERR 3
// ----------------------------------------------------------------------------
// Bus timing in clock cycles of 10 ns
// ----------------------------------------------------------------------------
`define FCSC_T_WRITE_NS 100
`define FCSC_T_READ_NS 100
`define FCSC_WR_CYC ((`FCSC_T_WRITE_NS + 9) / 10)
`define FCSC_RD_CYC ((`FCSC_T_READ_NS + 9) / 10)
`define FCSC_CNT_ZERO 4'h0
`endif

// file: core/fcsc_pkg.sv
// Types shared by the flash host controller.
package fcsc_pkg;
   // Operations that the user may request.
   typedef enum logic [2:0] {
      FCSC_OP_READ_ARRAY = 3'b000,
      FCSC_OP_READ_STATUS = 3'b001,
      FCSC_OP_PROGRAM = 3'b010,
      FCSC_OP_ERASE = 3'b011,
      FCSC_OP_CLEAR = 3'b100,
      FCSC_OP_SUSPEND = 3'b101,
      FCSC_OP_RESUME = 3'b110,
      FCSC_OP_READ = 3'b111
   } fcsc_op_type;
   // One user request.
   typedef struct packed {
      fcsc_op_type op;
      logic [20:0] addr;
      logic [7:0] data;
   } fcsc_req_type;
   // Decoded status flags.
   typedef struct packed {
      logic ready;
      logic suspended;
      logic erase_err;
      logic prog_err;
      logic supply_err;
   } fcsc_stat_type;
endpackage : fcsc_pkg

// file: verification/fcsc_flash_model.sv
// Behavioural flash device that answers the host controller's pin cycles.
`timescale 1ns/1ps
module fcsc_flash_model (
   input wire logic clk,
   input wire logic [20:0] addr,
   input wire logic [7:0] dq,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rp_n,
   input wire logic vpp_ok,
   output logic [7:0] q,
   output logic rb
);
   logic [7:0] mem [256];
   logic [7:0] dq_d, a_d;
   logic we_d, ce_d, tg, smode, busy, ers, susp, pf, v3, p4, e5;
   logic [1:0] setup;
   int cnt;
   wire lock = v3 | p4 | e5;
   wire [7:0] sr = {!busy | susp, susp, e5, p4, v3, 3'b000};
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      {we_d, ce_d, tg, smode, busy, ers, susp, pf, v3, p4, e5, setup, cnt} = '0;
   end
   assign rb = !rp_n | !busy | susp;
   // A released bus shows a pattern that flips every cycle, so stale data never passes.
   assign q = (!ce_n && !oe_n && rp_n) ? (smode ? sr : mem[addr[7:0]]) : {8{tg}} ^ 8'h5a;
   // Writes are decoded one cycle after the rising write strobe, from the held data.
   always @(posedge clk) begin
      tg <= !tg;
      we_d <= we_n;
      ce_d <= ce_n;
      dq_d <= dq;
      a_d <= addr[7:0];
      if (!rp_n || (busy && !vpp_ok)) begin
         if (busy) {v3, e5} <= {1'b1, e5 | ers};
         {busy, susp, setup} <= '0;
         if (!rp_n) smode <= 0;
      end else if (busy && !susp && cnt > 1) cnt <= cnt - 1;
      else if (busy && !susp) begin
         busy <= 0;
         if (ers) foreach (mem[i]) mem[i] <= 8'hff;
         else p4 <= p4 | pf;
      end
      if (rp_n && we_n && !we_d && !ce_d) begin
         if (setup == 2'd1) begin
            {setup, smode} <= {2'd0, 1'b1};
            if (!vpp_ok) v3 <= 1;
            else begin
               pf <= |(dq_d & ~mem[a_d]);
               mem[a_d] <= mem[a_d] & dq_d;
               {busy, ers, cnt} <= {2'b10, 32'd100};
            end
         end else if (setup == 2'd2) begin
            {setup, smode} <= {2'd0, 1'b1};
            if (dq_d != 8'hd0) {p4, e5} <= 2'b11;
            else if (!vpp_ok) v3 <= 1;
            else {busy, ers, cnt} <= {2'b11, 32'd300};
         end else if (busy && !susp) begin
            if (dq_d == 8'h70) smode <= 1;
            if (dq_d == 8'hb0 && ers) {susp, smode} <= 2'b11;
         end else if (susp) begin
            if (dq_d == 8'hff) smode <= 0;
            if (dq_d == 8'h70) smode <= 1;
            if (dq_d == 8'hd0) {susp, smode} <= 2'b01;
         end else case (dq_d)
            8'hff: smode <= lock;
            8'h70: smode <= 1;
            8'h50: {v3, p4, e5, smode} <= '0;
            8'h40, 8'h10: if (!lock) setup <= 2'd1;
            8'h20: if (!lock) setup <= 2'd2;
            default: ;
         endcase
      end
   end
endmodule : fcsc_flash_model

// file: verification/fcsc_host_tb.sv
// Self-checking bench for the flash host controller against a behavioural device.
`timescale 1ns/1ps
module fcsc_host_tb import fcsc_pkg::*; ;
   logic clk = 0, rst_n = 0, req_valid = 0, pd = 0, vpp = 1;
   fcsc_req_type req = '0;
   logic req_ready, resp_valid, dq_oe, ce_n, oe_n, we_n, rp_n, rb;
   logic [7:0] resp_data, dq_out, dq_in, d;
   logic [20:0] fa, a;
   fcsc_stat_type resp_stat;
   int fail_count = 0, n_compared = 0;
   always #5 clk = ~clk;
   fcsc_host i_fcsc_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
      .resp_stat(resp_stat), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .reset_powerdown_n(rp_n), .ready_busy_out(rb), .programming_supply_ok_level(vpp),
      .powerdown_req(pd));
   // Data reaches the device only while the controller enables its drive.
   fcsc_flash_model i_fcsc_flash_model (.clk(clk), .addr(fa), .dq(dq_out & {8{dq_oe}}),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .vpp_ok(vpp), .q(dq_in), .rb(rb));
   // Expected status byte, laid out as the status flags are packed.
   function automatic logic [7:0] sr(input logic r, s, e, p, v);
      return {r, s, e, p, v, 3'b000};
   endfunction : sr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // One request; it is raised only when ready was settled high, so one edge takes it.
   task automatic op(input fcsc_op_type o, input logic [20:0] ad, input logic [7:0] dt);
      int n;
      n = 0;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      req <= '{o, ad, dt};
      req_valid <= 1;
      @(negedge clk);
      req_valid <= 0;
      while (resp_valid !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n >= 300) check(8'h00, 8'h01);
   endtask : op
   // Polls status under a bound; a device stuck busy shows up in the next compare.
   task automatic wait_ready;
      for (int i = 0; i < 40; i++) begin
         op(FCSC_OP_READ_STATUS, '0, '0);
         if (resp_stat.ready === 1'b1) break;
      end
   endtask : wait_ready
   initial begin
      #500000;
      fail_count++;
      test_done;
   end
   initial begin
      void'($urandom(92));
      repeat (2) @(negedge clk);
      rst_n <= 1;
      a = 21'($urandom);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, 8'hff);
      for (int k = 0; k < 3; k++) begin
         a = 21'($urandom & 32'h1ffffc) | 21'(k);
         d = 8'($urandom & 32'h7e);
         op(FCSC_OP_PROGRAM, a, d);
         op(FCSC_OP_READ_ARRAY, '0, '0);
         op(FCSC_OP_READ, a, '0);
         check(resp_data, sr(0, 0, 0, 0, 0));
         wait_ready;
         check({resp_stat, 3'b000}, sr(1, 0, 0, 0, 0));
         op(FCSC_OP_READ_ARRAY, '0, '0);
         op(FCSC_OP_READ, a, '0);
         check(resp_data, d);
      end
      // Setting a cleared bit fails and locks the array until cleared.
      op(FCSC_OP_PROGRAM, a, ~d);
      wait_ready;
      check({resp_stat, 3'b000}, sr(1, 0, 0, 1, 0));
      op(FCSC_OP_READ_ARRAY, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, sr(1, 0, 0, 1, 0));
      // A program under the error lock is dropped silently and ready stays up.
      req <= '{FCSC_OP_PROGRAM, a, 8'h00};
      req_valid <= 1;
      repeat (2) @(negedge clk);
      req_valid <= 0;
      check({7'h00, req_ready}, 8'h01);
      op(FCSC_OP_CLEAR, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, 8'h00);
      op(FCSC_OP_READ_STATUS, '0, '0);
      check(resp_data, sr(1, 0, 0, 0, 0));
      vpp <= 0;
      op(FCSC_OP_PROGRAM, a, 8'h00);
      wait_ready;
      check({resp_stat, 3'b000}, sr(1, 0, 0, 0, 1));
      check(resp_data, sr(1, 0, 0, 0, 1));
      vpp <= 1;
      op(FCSC_OP_CLEAR, '0, '0);
      op(FCSC_OP_ERASE, a, '0);
      op(FCSC_OP_SUSPEND, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, sr(1, 1, 0, 0, 0));
      // A program during suspension is ignored, so its fresh byte stays erased.
      op(FCSC_OP_PROGRAM, a ^ 21'h1, 8'h00);
      op(FCSC_OP_READ_ARRAY, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, 8'h00);
      op(FCSC_OP_READ, a ^ 21'h1, '0);
      check(resp_data, 8'hff);
      op(FCSC_OP_RESUME, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, sr(0, 0, 0, 0, 0));
      wait_ready;
      op(FCSC_OP_READ_ARRAY, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, 8'hff);
      // Power-down in mid-suspension aborts the erase.
      op(FCSC_OP_ERASE, a, '0);
      op(FCSC_OP_SUSPEND, '0, '0);
      pd <= 1;
      repeat (6) @(negedge clk);
      pd <= 0;
      op(FCSC_OP_READ_STATUS, '0, '0);
      check({resp_stat, 3'b000}, sr(1, 0, 1, 0, 1));
      op(FCSC_OP_CLEAR, '0, '0);
      op(FCSC_OP_READ, a, '0);
      check(resp_data, 8'hff);
      test_done;
   end
endmodule : fcsc_host_tb
